/* logic/spf_device.sv */
module spf_device (
	input  wire logic                               clk,
	input  wire logic                               reset,
	spf_link_if.device                              link,
	input  wire logic [spf_pkg::WAKE_FLAGS-1:0]     wakeFlags,
	input  wire logic [spf_pkg::XCVR_FLAGS-1:0]     xcvrFlags,
	input  wire logic [spf_pkg::PIN_FLAGS-1:0]      pinFlags,
	input  wire logic [spf_pkg::PRE_FLAGS-1:0]      preFlags,
	input  wire logic [spf_pkg::CORE_FLAGS-1:0]     coreFlags,
	input  wire logic [spf_pkg::AUX_FLAGS-1:0]      auxFlags,
	input  wire logic                               serialErrClear,
	input  wire logic [7:0]                         readData,
	input  wire logic [7:0]                         extStatus,
	output logic                                    readStrobe,
	output logic                                    writeStrobe,
	output logic                                    bank_select_bit,
	output logic [4:0]                              register_index_field,
	output logic [7:0]                              payload_byte,
	output logic                                    serialError,
	output logic [7:0]                              statusByte
);
	// All state of the device end except the pin synchroniser in one packed record, registered once per clock.
	typedef struct packed {
		logic        sckPrev;     // Last synchronised serial clock.
		logic        selPrev;     // Last synchronised select.
		logic [4:0]  bitCount;    // Bits received this frame.
		logic [15:0] shiftIn;     // Incoming command bits.
		logic [15:0] shiftOut;    // Outgoing answer bits.
		logic        miso;        // Registered data pin.
		logic        misoOe;      // Registered pin enable.
		logic        readStrobe;  // Read pulse.
		logic        writeStrobe; // Write pulse.
		logic        bank;        // Bank of last command.
		logic [4:0]  index;       // Index of last command.
		logic [7:0]  payload;     // Payload of last command.
		logic        serialError; // Sticky communication failure.
		logic [7:0]  status;      // Registered summary byte.
	} spf_dev_type;

	spf_dev_type state;      // Registered state.
	spf_dev_type next_state; // Next state.
	logic [2:0]  pins;       // Synchronised frame-active, clock and data.
	logic [7:0]  summary;    // Live summary byte.
	logic        sckRise;    // Serial clock rising edge seen.
	logic        sckFall;    // Serial clock falling edge seen.
	logic        selFall;    // Frame start.
	logic        selRise;    // Frame end.
	logic [15:0] cmd;        // Completed command word.
	logic        writeOk;    // Write with good parity.

	// The link pins come from the master's domain, so they pass two flops first.
	// Select is inverted on the way in: the synchroniser clears to zero on reset, and zero
	// must mean an idle link there, or a phantom frame would follow every reset and leave
	// a serial error behind it.
	spf_sync #(
		.WIDTH(3)
	) pinSync (
		.clk  (clk),
		.reset(reset),
		.din  ({~link.selectN, link.sck, link.mosi}),
		.dout (pins)
	);

	// Summary byte; each group follows its sources, so clearing a source clears it.
	// Only the serial-error bit is held here; the other groups trust their source flags to be
	// sticky until read, so a source that pulses for one cycle lights its group for one cycle.
	// Bit zero has no group and always reads zero.
	always_comb begin
		summary                       = spf_pkg::BYTE_RESET;
		summary[spf_pkg::SUM_SERIAL]  = state.serialError;
		summary[spf_pkg::SUM_WAKE]    = |wakeFlags;
		summary[spf_pkg::SUM_XCVR]    = |xcvrFlags;
		summary[spf_pkg::SUM_PIN]     = |pinFlags;
		summary[spf_pkg::SUM_PRE]     = |preFlags;
		summary[spf_pkg::SUM_CORE]    = |coreFlags;
		summary[spf_pkg::SUM_AUX]     = |auxFlags;
	end

	// Edge detection on the synchronised pins.
	// Each edge is seen three system clocks after it reaches the pin, two for the synchroniser
	// and one for this compare; the master's half period of four clocks leaves room for that.
	always_comb begin
		sckRise = pins[1] & ~state.sckPrev;
		sckFall = ~pins[1] & state.sckPrev;
		// Frame start and end are the edges of the inverted select.
		selFall = pins[2] & ~state.selPrev;
		selRise = ~pins[2] & state.selPrev;
		// The command is complete only once select rises; before that it is partial.
		cmd     = state.shiftIn;
		// Parity is checked over the fifteen other bits; a read needs no check.
		writeOk = (cmd[spf_pkg::POS_ACCESS] == spf_pkg::ACCESS_WRITE)
			&& (cmd[spf_pkg::POS_PARITY] == spf_pkg::spf_parity_type_fn(cmd));
	end

	// Frame engine: shift on clock edges, decode a read at its seventh bit and a write when select rises.
	// Strobes are single-cycle pulses, so they drop back to zero at the top of every pass.
	// The bit counter is five bits wide: a frame of forty-eight clocks wraps it back to sixteen
	// and would pass the length check, a limitation accepted to keep the counter small.
	always_comb begin
		next_state             = state;
		next_state.sckPrev     = pins[1];
		next_state.selPrev     = pins[2];
		next_state.readStrobe  = 1'h0;
		next_state.writeStrobe = 1'h0;
		// The summary byte is registered so that the status output comes from a flop.
		next_state.status      = summary;
		// A clear and a new failure in the same cycle leave the flag set.
		if (serialErrClear) begin
			// Clear first so a new failure below still wins.
			next_state.serialError = 1'h0;
		end
		if (selFall) begin
			// Frame start: the answer line is driven from here until the frame ends.
			// Load status then the extended byte; the register byte replaces it later on reads.
			next_state.bitCount = 5'h00;
			next_state.shiftOut = {summary, extStatus};
			next_state.miso     = summary[7];
			next_state.misoOe   = 1'h1;
		end else if (pins[2]) begin
			// Inside a frame: take command bits on rising clock, move answer bits on falling clock.
			if (sckRise) begin
				// Command bits arrive most significant first.
				next_state.shiftIn  = {state.shiftIn[14:0], pins[0]};
				next_state.bitCount = state.bitCount + 5'h01;
				// Once access, bank and index are in, fetch the register for a read.
				// Six bits are already held and the seventh, the last index bit, is on the pin,
				// so the access bit sits at position five and the bank bit at position four.
				if (state.bitCount == 5'h06) begin
					next_state.bank  = state.shiftIn[4];
					next_state.index = {state.shiftIn[3:0], pins[0]};
					if (state.shiftIn[5] == spf_pkg::ACCESS_READ) begin
						// Asked early so the register byte is ready when bit seven leaves.
						next_state.readStrobe = 1'h1;
					end
				end
			end
			if (sckFall) begin
				// The next answer bit goes out on each falling clock.
				next_state.shiftOut = {state.shiftOut[14:0], 1'h0};
				next_state.miso     = state.shiftOut[14];
				// Register data arrives well before bit 7 leaves the device.
				if (state.bitCount == 5'h08 && state.shiftIn[7] == spf_pkg::ACCESS_READ) begin
					next_state.shiftOut = {readData, 8'h00};
					next_state.miso     = readData[7];
				end
			end
		end
		if (selRise) begin
			// Frame end: release the answer line so that it rests low between frames.
			next_state.misoOe = 1'h0;
			next_state.miso   = 1'h0;
			// A frame of any other length modulo thirty-two is a communication failure.
			if (state.bitCount != 5'(spf_pkg::FRAME_BITS)) begin
				next_state.serialError = 1'h1;
			end else if (cmd[spf_pkg::POS_ACCESS] == spf_pkg::ACCESS_WRITE) begin
				// The write strobe and payload are applied only here, once all sixteen bits and the parity are in.
				if (writeOk) begin
					next_state.writeStrobe = 1'h1;
					next_state.bank        = cmd[spf_pkg::POS_BANK];
					next_state.index       = cmd[spf_pkg::POS_INDEX_HI:spf_pkg::POS_INDEX_LO];
					next_state.payload     = cmd[7:0];
				end else begin
					// Bad parity: no write strobe or payload is stored and the failure is reported; bank and index already changed at bit seven.
					next_state.serialError = 1'h1;
				end
			end
		end
	end

	// Register all state; reset clears every flag.
	// The reset is synchronous, so it takes effect only on a running clock.
	always_ff @(posedge clk) begin
		if (reset) begin
			// Zero is the idle level of every synchronised pin, so no false edge follows reset.
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Every output comes straight from a register of the state.
	// The answer line is low whenever its enable is low.
	assign link.miso            = state.miso;
	assign link.misoOe          = state.misoOe;
	assign readStrobe           = state.readStrobe;
	assign writeStrobe          = state.writeStrobe;
	assign bank_select_bit      = state.bank;
	assign register_index_field = state.index;
	assign payload_byte         = state.payload;
	assign serialError          = state.serialError;
	assign statusByte           = state.status;
endmodule

/* logic/spf_pkg.sv */
package spf_pkg;

	// Frame length in bits and field positions within a command word.
	localparam int          FRAME_BITS    = 16;
	localparam int          POS_ACCESS    = 15;
	localparam int          POS_BANK      = 14;
	localparam int          POS_INDEX_HI  = 13;
	localparam int          POS_INDEX_LO  = 9;
	localparam int          POS_PARITY    = 8;
	localparam int          POS_STATUS_LO = 8;
	// Access-type and bank encodings.
	localparam logic        ACCESS_READ   = 1'h0;
	localparam logic        ACCESS_WRITE  = 1'h1;
	localparam logic        BANK_MAIN     = 1'h0;
	localparam logic        BANK_SAFE     = 1'h1;
	// Flag counts per summary group.
	localparam int          WAKE_FLAGS    = 8;
	localparam int          XCVR_FLAGS    = 9;
	localparam int          PIN_FLAGS     = 6;
	localparam int          PRE_FLAGS     = 8;
	localparam int          CORE_FLAGS    = 5;
	localparam int          AUX_FLAGS     = 15;
	// Summary byte bit positions, MSB first.
	localparam int          SUM_SERIAL    = 7;
	localparam int          SUM_WAKE      = 6;
	localparam int          SUM_XCVR      = 5;
	localparam int          SUM_PIN       = 4;
	localparam int          SUM_PRE       = 3;
	localparam int          SUM_CORE      = 2;
	localparam int          SUM_AUX       = 1;
	// Reset values.
	localparam logic [15:0] WORD_RESET    = 16'h0000;
	localparam logic [7:0]  BYTE_RESET    = 8'h00;
	// Master serial clock half period in system clocks (20 ns each, 160 ns period).
	localparam int          SCK_HALF_NS   = 80;
	localparam int          CLK_NS        = 20;
	localparam int          SCK_HALF_CYC  = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;

	// Parity value that a write must carry: 1 when the other fifteen bits hold an even count of ones.
	function automatic logic spf_parity_type_fn(input logic [15:0] word);
		spf_parity_type_fn = ~(^{word[15:9], word[7:0]});
	endfunction

endpackage

/* logic/spf_link_if.sv */
interface spf_link_if;
	logic selectN; // Frame select, active low, driven by master.
	logic sck;     // Serial clock, driven by master, idles low.
	logic mosi;    // Master to device data.
	logic miso;    // Device to master data.
	logic misoOe;  // Device drives miso while high.

	modport device (
		input  selectN,
		input  sck,
		input  mosi,
		output miso,
		output misoOe
	);

	modport master (
		input  miso,
		input  misoOe,
		output selectN,
		output sck,
		output mosi
	);
endinterface

/* logic/spf_sync.sv */
// Two-flop synchroniser for a bundle of levels from outside the clock domain.
module spf_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} spf_sync_type;

	spf_sync_type state;      // Registered state.
	spf_sync_type next_state; // Next state.

	// First stage feeds only the second stage.
	always_comb begin
		next_state        = state;
		next_state.first  = din;
		next_state.second = state.first;
	end

	// Register the state; reset clears both stages.
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign dout = state.second;
endmodule

/* logic/spf_master.sv */
// Master end: sends one command word per request and returns the answer.
module spf_master (
	input  wire logic       clk,
	input  wire logic       reset,
	spf_link_if.master      link,
	input  wire logic       start,
	input  wire logic       isWrite,
	input  wire logic       bank_select_bit,
	input  wire logic [4:0] register_index_field,
	input  wire logic [7:0] payload_byte,
	output logic            busy,
	output logic            done,
	output logic [15:0]     answer
);
	typedef enum logic [1:0] {
		M_IDLE  = 2'h0,
		M_SHIFT = 2'h1,
		M_END   = 2'h3
	} spf_mstate_type;

	typedef struct packed {
		spf_mstate_type fsm;     // Sequencer state.
		logic [7:0]     div;     // Half-period divider.
		logic [4:0]     bits;    // Bits sent.
		logic [15:0]    txWord;  // Outgoing word.
		logic [15:0]    rxWord;  // Incoming word.
		logic           sck;     // Serial clock.
		logic           selN;    // Select, active low.
		logic           busy;    // Transfer in progress.
		logic           done;    // Completion pulse.
		logic [15:0]    answer;  // Last answer.
	} spf_mst_type;

	spf_mst_type state;      // Registered state.
	spf_mst_type next_state; // Next state.
	logic [15:0] word;       // Command assembled from the request.
	logic        tick;       // Divider enable pulse.
	logic        misoSync;   // Synchronised device data.

	// The answer pin is a foreign input, so it is synchronised.
	spf_sync #(
		.WIDTH(1)
	) misoSyncer (
		.clk  (clk),
		.reset(reset),
		.din  (link.miso),
		.dout (misoSync)
	);

	// Build the word; reads force parity and payload to zero.
	always_comb begin
		word = {isWrite, bank_select_bit, register_index_field, 1'h0, 8'h00};
		if (isWrite) begin
			word[7:0]                 = payload_byte;
			word[spf_pkg::POS_PARITY] = spf_pkg::spf_parity_type_fn(word);
		end else begin
			word[spf_pkg::POS_PARITY] = 1'h0;
		end
		tick = (state.div == 8'(spf_pkg::SCK_HALF_CYC - 1));
	end

	// Sequencer: command bits change on the falling clock, and the device samples them on the rising one.
	always_comb begin
		next_state      = state;
		next_state.done = 1'h0;
		next_state.div  = tick ? 8'h00 : state.div + 8'h01;
		case (state.fsm)
			M_IDLE: begin
				next_state.div = 8'h00;
				if (start) begin
					next_state.fsm    = M_SHIFT;
					next_state.txWord = word;
					next_state.bits   = 5'h00;
					next_state.selN   = 1'h0;
					next_state.busy   = 1'h1;
				end
			end
			M_SHIFT: begin
				if (tick) begin
					next_state.sck = ~state.sck;
					if (!state.sck) begin
						next_state.bits   = state.bits + 5'h01;
					end else begin
						// The answer bit is taken on the falling clock: the trip through both
						// synchronisers outlasts half a period, so the bit launched on the last
						// fall is settled now, while at the rising clock it is not.
						next_state.rxWord = {state.rxWord[14:0], misoSync};
						next_state.txWord = {state.txWord[14:0], 1'h0};
						if (state.bits == 5'(spf_pkg::FRAME_BITS)) begin
							next_state.fsm = M_END;
						end
					end
				end
			end
			M_END: begin
				if (tick) begin
					next_state.selN   = 1'h1;
					next_state.busy   = 1'h0;
					next_state.done   = 1'h1;
					next_state.answer = state.rxWord;
					next_state.fsm    = M_IDLE;
				end
			end
			default: begin
				next_state.fsm = M_IDLE;
			end
		endcase
	end

	// Register the state.
	always_ff @(posedge clk) begin
		if (reset) begin
			state      <= '0;
			state.selN <= 1'h1;
			state.fsm  <= M_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign link.selectN = state.selN;
	assign link.sck     = state.sck;
	assign link.mosi    = state.txWord[15];
	assign busy         = state.busy;
	assign done         = state.done;
	assign answer       = state.answer;
endmodule

/* sim/spf_link_assertions.sv */
// Watches the serial link between the two design ends.
module spf_link_assertions (
	input wire logic clk,
	input wire logic reset,
	input wire logic selectN,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic misoOe
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	logic        sckQ;      // Serial clock one cycle ago.
	logic [4:0]  riseCount; // Serial clock rises seen in this frame.
	logic [15:0] shiftWord; // Command word as the device should see it.

	// Counts rises and collects the command; a deselected link clears the count.
	always_ff @(posedge clk) begin
		if (reset) begin
			sckQ      <= 1'h0;
			riseCount <= 5'h00;
			shiftWord <= 16'h0000;
		end else begin
			sckQ <= sck;
			if (selectN) begin
				riseCount <= 5'h00;
			end else if (sck && !sckQ) begin
				riseCount <= riseCount + 5'h01;
				shiftWord <= {shiftWord[14:0], mosi};
			end
		end
	end

	sck_idle_a: assert property (selectN |-> !sck)
		else $error("serial clock high while deselected");
	sck_high_a: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
		else $error("serial clock high phase wrong length");
	sck_low_a: assert property ($fell(sck) |-> (!sck)[*4])
		else $error("serial clock low phase too short");
	bit_count_a: assert property ($rose(selectN) |-> riseCount == 5'h10)
		else $error("frame did not carry sixteen bits");
	mosi_hold_a: assert property ($rose(sck) |=> $stable(mosi)[*3])
		else $error("command bit changed while clock high");
	frame_gap_a: assert property ($rose(selectN) |-> selectN[*3])
		else $error("frames too close together");
	oe_on_a: assert property ($fell(selectN) |-> ##[1:4] misoOe)
		else $error("device did not drive its answer line");
	oe_off_a: assert property ($rose(selectN) |-> ##[1:4] !misoOe)
		else $error("device kept driving after the frame");
	write_parity_a: assert property ($rose(selectN) && shiftWord[15]
		|-> shiftWord[8] == ~^{shiftWord[15:9], shiftWord[7:0]})
		else $error("write carried wrong parity");
	read_zero_a: assert property ($rose(selectN) && !shiftWord[15] |-> shiftWord[8:0] == 9'h000)
		else $error("read carried nonzero parity or payload");
endmodule

/* sim/spi_frame_and_status_flags_bench.sv */
`define CHECK_EQ(got, exp) begin checksDone++; if ((got) !== (exp)) begin miscompares++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module spi_frame_and_status_flags_bench;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk, reset, start, isWrite, bankSel, serialErrClear;
	logic [50:0] flagVec;                  // All source flags, wake group lowest.
	logic [4:0]  idxSel, idxOut;
	logic [7:0]  payload, payloadOut, readData, extStatus, statusByte, statusByte2;
	logic [15:0] answer;
	logic        busy, done, readStrobe, writeStrobe, writeStrobe2, bankOut, serialError, serialError2;
	int          miscompares, checksDone, rdSeen, wrSeen, wr2Seen, cycles;

	spf_link_if linkBus ();  // Joins the two design ends.
	spf_link_if badBus ();   // Driven by the bench in the master's place.

	spf_master spf_master_inst (.clk, .reset, .link(linkBus.master), .start, .isWrite,
		.bank_select_bit(bankSel), .register_index_field(idxSel), .payload_byte(payload),
		.busy, .done, .answer);
	spf_device spf_device_inst (.clk, .reset, .link(linkBus.device), .wakeFlags(flagVec[7:0]),
		.xcvrFlags(flagVec[16:8]), .pinFlags(flagVec[22:17]), .preFlags(flagVec[30:23]),
		.coreFlags(flagVec[35:31]), .auxFlags(flagVec[50:36]), .serialErrClear, .readData,
		.extStatus, .readStrobe, .writeStrobe, .bank_select_bit(bankOut),
		.register_index_field(idxOut), .payload_byte(payloadOut), .serialError, .statusByte);
	spf_device spf_device_inst2 (.clk, .reset, .link(badBus.device), .wakeFlags(flagVec[7:0]),
		.xcvrFlags(flagVec[16:8]), .pinFlags(flagVec[22:17]), .preFlags(flagVec[30:23]),
		.coreFlags(flagVec[35:31]), .auxFlags(flagVec[50:36]), .serialErrClear, .readData,
		.extStatus, .readStrobe(), .writeStrobe(writeStrobe2), .bank_select_bit(),
		.register_index_field(), .payload_byte(), .serialError(serialError2), .statusByte(statusByte2));
	spf_link_assertions spf_link_assertions_inst (.clk, .reset, .selectN(linkBus.selectN),
		.sck(linkBus.sck), .mosi(linkBus.mosi), .miso(linkBus.miso), .misoOe(linkBus.misoOe));

	// Free-running system clock at 50 MHz.
	always #10 clk = ~clk;

	// Strobes last one cycle, so they are counted at every rising edge.
	always @(posedge clk) begin
		if (readStrobe === 1'h1) rdSeen++;
		if (writeStrobe === 1'h1) wrSeen++;
		if (writeStrobe2 === 1'h1) wr2Seen++;
	end

	// Cuts a hang short; the ceiling is about five times the expected run.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			summarize();
		end
	end

	// Summary byte expected for the given sources and serial-error state.
	function automatic logic [7:0] expStatus(input logic [50:0] v, input logic e);
		return {e, |v[7:0], |v[16:8], |v[22:17], |v[30:23], |v[35:31], |v[50:36], 1'h0};
	endfunction

	// One command through the master end; waits for its completion pulse.
	task automatic xfer(input logic w, input logic b, input logic [4:0] idx, input logic [7:0] d,
		output logic [15:0] ans);
		int n;
		@(posedge clk) #2;
		isWrite = w;
		bankSel = b;
		idxSel = idx;
		payload = d;
		start = 1'h1;
		@(posedge clk) #2;
		start = 1'h0;
		`CHECK_EQ(busy, 1'h1)
		n = 0;
		do begin
			@(posedge clk) #1;
			n++;
		end while (done !== 1'h1 && n < 400);
		ans = answer;
		`CHECK_EQ(n < 400, 1'h1)
		`CHECK_EQ(busy, 1'h0)
		repeat (6) @(posedge clk);
	endtask

	// Hand-made frame of the given bit count; the data line is left toggled afterwards.
	task automatic rawFrame(input logic [15:0] w, input int bits);
		int k;
		@(posedge clk) #2;
		badBus.selectN = 1'h0;
		for (k = 15; k > 15 - bits; k--) begin
			badBus.mosi = w[k];
			repeat (4) @(posedge clk);
			#2 badBus.sck = 1'h1;
			repeat (4) @(posedge clk);
			#2 badBus.sck = 1'h0;
		end
		repeat (4) @(posedge clk);
		#2 badBus.selectN = 1'h1;
		badBus.mosi = ~badBus.mosi;
		repeat (8) @(posedge clk);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic summarize();
		$display("checks %0d miscompares %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence: reset, per-flag reads, writes, then faulty frames on the second link.
	initial begin
		logic [15:0] ans, w;
		clk = 1'h0; reset = 1'h1; start = 1'h0; isWrite = 1'h0; bankSel = 1'h0; idxSel = 5'h00;
		payload = 8'h00; flagVec = '0; serialErrClear = 1'h0; readData = 8'h00; extStatus = 8'h96;
		badBus.selectN = 1'h1; badBus.sck = 1'h0; badBus.mosi = 1'h0;
		repeat (12) @(posedge clk);
		#2 reset = 1'h0;
		@(posedge clk) #2;
		`CHECK_EQ(statusByte, 8'h00)
		`CHECK_EQ(serialError, 1'h0)
		// Each source flag alone must light exactly its own summary bit.
		for (int i = 0; i < 51; i++) begin
			flagVec = 51'h1 << i;
			readData = 8'hC3 ^ 8'(i);
			repeat (2) @(posedge clk);
			xfer(1'h0, i[0], i[4:0], 8'h00, ans);
			`CHECK_EQ(ans, {expStatus(flagVec, 1'h0), 8'hC3 ^ 8'(i)})
			`CHECK_EQ(statusByte, expStatus(flagVec, 1'h0))
			`CHECK_EQ(bankOut, i[0])
			`CHECK_EQ(idxOut, i[4:0])
			`CHECK_EQ(rdSeen, i + 1)
		end
		flagVec = '0;
		repeat (2) @(posedge clk);
		xfer(1'h0, 1'h0, 5'h1F, 8'h00, ans);
		`CHECK_EQ(ans[15:8], 8'h00)
		// Back-to-back writes: stored, no read strobe, extended status returned.
		xfer(1'h1, 1'h1, 5'h0A, 8'h3C, ans);
		`CHECK_EQ(wrSeen, 1)
		`CHECK_EQ(payloadOut, 8'h3C)
		`CHECK_EQ(ans[7:0], 8'h96)
		xfer(1'h1, 1'h0, 5'h1F, 8'hFF, ans);
		`CHECK_EQ(wrSeen, 2)
		`CHECK_EQ(rdSeen, 52)
		`CHECK_EQ(serialError, 1'h0)
		// Wrong parity is refused and flagged until cleared.
		w = 16'h865A;
		w[8] = ~^{w[15:9], w[7:0]};
		rawFrame(w ^ 16'h0100, 16);
		`CHECK_EQ(wr2Seen, 0)
		`CHECK_EQ(serialError2, 1'h1)
		`CHECK_EQ(statusByte2[7], 1'h1)
		@(posedge clk) #2 serialErrClear = 1'h1;
		@(posedge clk) #2 serialErrClear = 1'h0;
		repeat (3) @(posedge clk);
		`CHECK_EQ(serialError2, 1'h0)
		`CHECK_EQ(statusByte2[7], 1'h0)
		rawFrame(w, 16);
		`CHECK_EQ(wr2Seen, 1)
		`CHECK_EQ(serialError2, 1'h0)
		// A frame one bit short counts as a failure and gives no write strobe.
		rawFrame(w, 15);
		`CHECK_EQ(wr2Seen, 1)
		`CHECK_EQ(serialError2, 1'h1)
		summarize();
	end
endmodule
